/* File: hdl/frp_pkg.sv */
/*
  Shared constants for the dual-direction FIFO pointer, flag and parity
  controller: register indices, field positions and reset values.
  Assumes a 16-bit register port with one register per index.

*/
package frp_pkg;
  localparam int FRP_DEPTH_DEF = 512;
  localparam int FRP_DW        = 16;
  localparam int FRP_RAW       = 4;

  // Register indices
  localparam logic [3:0] FRP_REG_STATUS = 4'h0;
  localparam logic [3:0] FRP_REG_MASK   = 4'h1;
  localparam logic [3:0] FRP_REG_CFG5   = 4'h2;
  localparam logic [3:0] FRP_REG_CFG7   = 4'h3;
  localparam logic [3:0] FRP_REG_AB_AE  = 4'h4;
  localparam logic [3:0] FRP_REG_AB_AF  = 4'h5;
  localparam logic [3:0] FRP_REG_BA_AE  = 4'h6;
  localparam logic [3:0] FRP_REG_BA_AF  = 4'h7;

  // Field positions
  localparam int FRP_ST_RD_PERR   = 9;
  localparam int FRP_ST_WR_PERR   = 10;
  localparam int FRP_C5_REREAD_PR = 2;
  localparam int FRP_C5_REWRITE_PR = 3;
  localparam int FRP_C7_GEN_BA    = 8;
  localparam int FRP_C7_GEN_AB    = 9;
  localparam int FRP_C7_EVEN      = 10;
  localparam int FRP_C7_ERR_EXTERNAL_FLAG_A  = 11;
  // Flag bits in status 7:0: AB empty, aempty, afull, full, then BA
  localparam int FRP_FL_AB        = 0;
  localparam int FRP_FL_BA        = 4;

  // Reset values
  localparam logic [7:0]  FRP_FLAGS_RST = 8'h33;
  localparam logic [15:0] FRP_OFS_RST   = 16'h0008;
endpackage : frp_pkg

/* File: hdl/frp_flag_dec.sv */
/*
  Flag decoder for one FIFO direction.
  Assumes pointers carry one wrap bit above the address bits.
*/
`timescale 1ns/1ns
`default_nettype none
module frp_flag_dec #(
  parameter int DEPTH = 512,
  parameter int PW    = 10
) (
  input  wire logic [PW-1:0] wr_ptr,
  input  wire logic [PW-1:0] rd_ptr,
  input  wire logic [PW-1:0] full_ref,
  input  wire logic [PW-1:0] empty_ref,
  input  wire logic [PW-1:0] ae_ofs,
  input  wire logic [PW-1:0] af_ofs,
  output logic               empty,
  output logic               aempty,
  output logic               afull,
  output logic               full
);
  localparam logic [PW-1:0] DEPTH_W = PW'(DEPTH);
  logic [PW-1:0] count;
  logic [PW-1:0] span;

  // Wrap bit makes the difference exact up to a full FIFO
  assign count = wr_ptr - rd_ptr;
  assign span  = wr_ptr - full_ref;
  assign empty  = (rd_ptr == empty_ref);
  assign full   = (span == DEPTH_W);
  assign aempty = (count <= ae_ofs);
  assign afull  = (count >= DEPTH_W - af_ofs);
endmodule // frp_flag_dec
`default_nettype wire

/* File: hdl/frp_parity.sv */
/*
  Ninth-bit parity generator and checker for one byte lane.
  Assumes even selects even parity over all nine bits.
*/
`timescale 1ns/1ns
`default_nettype none
module frp_parity (
  input  wire logic [7:0] data_byte,
  input  wire logic       ninth_in,
  input  wire logic       gen_en,
  input  wire logic       even,
  output logic            ninth_out,
  output logic            par_err
);
  logic gen_bit;

  // Odd parity wants nine bits with an odd count of ones
  assign gen_bit   = even ? ^data_byte : ~^data_byte;
  assign ninth_out = gen_en ? gen_bit : ninth_in;
  // Checking only runs while generation is off
  assign par_err   = ~gen_en & (gen_bit != ninth_in);
endmodule // frp_parity
`default_nettype wire

/* File: hdl/frp_fifo_ctrl.sv */
/*
  Pointer, flag, reread/rewrite and parity controller for a pair of
  FIFOs, A-to-B and B-to-A. The memories sit outside and use the
  address outputs. Assumes all strobes are synchronous to sys_clk and
  that RAM read data for ab_rd_addr is valid while ab_read is high.
*/
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module frp_fifo_ctrl
  import frp_pkg::*;
#(
  parameter int DEPTH = FRP_DEPTH_DEF
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic [FRP_RAW-1:0]      reg_addr,
  input  wire logic [FRP_DW-1:0]       reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [FRP_DW-1:0]            reg_rdata,
  input  wire logic                    ab_write,
  input  wire logic                    ab_read,
  input  wire logic                    ba_write,
  input  wire logic                    ba_read,
  input  wire logic                    reread_strobe,
  input  wire logic                    save_read_mark,
  input  wire logic                    rewrite_strobe,
  input  wire logic                    save_write_mark,
  input  wire logic [7:0]              ab_rd_byte,
  input  wire logic                    ab_rd_ninth,
  input  wire logic [7:0]              port_b_wr_byte,
  input  wire logic                    port_b_wr_ninth,
  output logic [$clog2(DEPTH)-1:0]     ab_wr_addr,
  output logic [$clog2(DEPTH)-1:0]     ab_rd_addr,
  output logic [$clog2(DEPTH)-1:0]     ba_wr_addr,
  output logic [$clog2(DEPTH)-1:0]     ba_rd_addr,
  output logic [7:0]                   fifo_flags,
  output logic                         port_b_ninth_bit,
  output logic                         port_a_low_ninth_bit,
  output logic                         external_flag_a,
  output logic                         irq
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] ONE = PW'(1);

  // Only the two documented depths are served
  generate
    if (DEPTH != 512 && DEPTH != 1024) begin : g_bad_depth
      $error("frp_fifo_ctrl: DEPTH must be 512 or 1024");
    end
  endgenerate

  typedef struct packed {
    logic [PW-1:0]     ab_wr;
    logic [PW-1:0]     ab_rd;
    logic [PW-1:0]     ab_mark;
    logic [PW-1:0]     ba_wr;
    logic [PW-1:0]     ba_rd;
    logic [PW-1:0]     ba_mark;
    logic [7:0]        flags;
    logic [1:0]        perr;
    logic [1:0]        mask;
    logic [1:0]        prot;
    logic [3:0]        par_cfg;
    logic [PW-1:0]     ab_ae;
    logic [PW-1:0]     ab_af;
    logic [PW-1:0]     ba_ae;
    logic [PW-1:0]     ba_af;
    logic [FRP_DW-1:0] rdata;
    logic              pb_ninth;
    logic              ba_ninth;
    logic              flag_a;
    logic              irq;
  } frp_state_s;

  frp_state_s s_r;
  frp_state_s s_nxt;

  logic          ab_push;
  logic          ab_pop;
  logic          ba_push;
  logic          ba_pop;
  logic          ab_ninth_gen;
  logic          ab_perr;
  logic          ba_ninth_gen;
  logic          ba_perr;
  logic [PW-1:0] ab_full_ref;
  logic [PW-1:0] ba_empty_ref;
  logic [3:0]    ab_fl;
  logic [3:0]    ba_fl;
  logic [1:0]    perr_clr;
  logic [1:0]    perr_set;

  // Config 7 bits 11:8 held as par_cfg[3:0]
  localparam int PC_GEN_BA = FRP_C7_GEN_BA - 8;
  localparam int PC_GEN_AB = FRP_C7_GEN_AB - 8;
  localparam int PC_EVEN   = FRP_C7_EVEN - 8;
  localparam int PC_EXTERNAL_FLAG_A   = FRP_C7_ERR_EXTERNAL_FLAG_A - 8;

  // Accepted transfers; refused ones leave the pointers alone
  assign ab_push = ab_write & ~s_r.flags[FRP_FL_AB + 3];
  assign ab_pop  = ab_read  & ~s_r.flags[FRP_FL_AB];
  assign ba_push = ba_write & ~s_r.flags[FRP_FL_BA + 3];
  assign ba_pop  = ba_read  & ~s_r.flags[FRP_FL_BA];

  // Protection only swaps the compare reference
  assign ab_full_ref  = s_nxt.prot[0] ? s_nxt.ab_mark : s_nxt.ab_rd;
  assign ba_empty_ref = s_nxt.prot[1] ? s_nxt.ba_mark : s_nxt.ba_wr;

  // Flags decode the next pointers so they register with them
  frp_flag_dec #(
    .DEPTH     (DEPTH),
    .PW        (PW)
  ) u_ab_flags (
    .wr_ptr    (s_nxt.ab_wr),
    .rd_ptr    (s_nxt.ab_rd),
    .full_ref  (ab_full_ref),
    .empty_ref (s_nxt.ab_wr),
    .ae_ofs    (s_nxt.ab_ae),
    .af_ofs    (s_nxt.ab_af),
    .empty     (ab_fl[0]),
    .aempty    (ab_fl[1]),
    .afull     (ab_fl[2]),
    .full      (ab_fl[3])
  );

  frp_flag_dec #(
    .DEPTH     (DEPTH),
    .PW        (PW)
  ) u_ba_flags (
    .wr_ptr    (s_nxt.ba_wr),
    .rd_ptr    (s_nxt.ba_rd),
    .full_ref  (s_nxt.ba_rd),
    .empty_ref (ba_empty_ref),
    .ae_ofs    (s_nxt.ba_ae),
    .af_ofs    (s_nxt.ba_af),
    .empty     (ba_fl[0]),
    .aempty    (ba_fl[1]),
    .afull     (ba_fl[2]),
    .full      (ba_fl[3])
  );

  // A-to-B read lane toward port B
  frp_parity u_ab_par (
    .data_byte (ab_rd_byte),
    .ninth_in  (ab_rd_ninth),
    .gen_en    (s_r.par_cfg[PC_GEN_AB]),
    .even      (s_r.par_cfg[PC_EVEN]),
    .ninth_out (ab_ninth_gen),
    .par_err   (ab_perr)
  );

  // B-to-A write lane into memory
  frp_parity u_ba_par (
    .data_byte (port_b_wr_byte),
    .ninth_in  (port_b_wr_ninth),
    .gen_en    (s_r.par_cfg[PC_GEN_BA]),
    .even      (s_r.par_cfg[PC_EVEN]),
    .ninth_out (ba_ninth_gen),
    .par_err   (ba_perr)
  );

  // Sticky error sources and write-one clears
  assign perr_set = {ba_push & ba_perr, ab_pop & ab_perr};
  assign perr_clr = (reg_wr && reg_addr == FRP_REG_STATUS) ?
                    {reg_wdata[FRP_ST_WR_PERR], reg_wdata[FRP_ST_RD_PERR]} :
                    2'h0;

  // Next state of the whole controller
  always_comb begin
    s_nxt = s_r;

    // A-to-B pointers; reread beats a same-cycle read
    if (reread_strobe) begin
      s_nxt.ab_rd = s_r.ab_mark;
    end else if (ab_pop) begin
      s_nxt.ab_rd = s_r.ab_rd + ONE;
    end
    if (save_read_mark) begin
      s_nxt.ab_mark = s_r.ab_rd;
    end
    if (ab_push) begin
      s_nxt.ab_wr = s_r.ab_wr + ONE;
    end

    // B-to-A pointers; rewrite beats a same-cycle write
    if (rewrite_strobe) begin
      s_nxt.ba_wr = s_r.ba_mark;
    end else if (ba_push) begin
      s_nxt.ba_wr = s_r.ba_wr + ONE;
    end
    if (save_write_mark) begin
      s_nxt.ba_mark = s_r.ba_wr;
    end
    if (ba_pop) begin
      s_nxt.ba_rd = s_r.ba_rd + ONE;
    end

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        FRP_REG_MASK: begin
          s_nxt.mask = {reg_wdata[FRP_ST_WR_PERR],
                        reg_wdata[FRP_ST_RD_PERR]};
        end
        FRP_REG_CFG5: begin
          s_nxt.prot = {reg_wdata[FRP_C5_REWRITE_PR],
                        reg_wdata[FRP_C5_REREAD_PR]};
        end
        FRP_REG_CFG7: begin
          s_nxt.par_cfg = reg_wdata[FRP_C7_ERR_EXTERNAL_FLAG_A:FRP_C7_GEN_BA];
        end
        FRP_REG_AB_AE: s_nxt.ab_ae = reg_wdata[PW-1:0];
        FRP_REG_AB_AF: s_nxt.ab_af = reg_wdata[PW-1:0];
        FRP_REG_BA_AE: s_nxt.ba_ae = reg_wdata[PW-1:0];
        FRP_REG_BA_AF: s_nxt.ba_af = reg_wdata[PW-1:0];
        default: ;
      endcase
    end

    // Set wins over a clear in the same cycle
    s_nxt.perr = (s_r.perr & ~perr_clr) | perr_set;

    // Ninth bits hold their last transferred value
    if (ab_pop) begin
      s_nxt.pb_ninth = ab_ninth_gen;
    end
    if (ba_push) begin
      s_nxt.ba_ninth = ba_ninth_gen;
    end

    s_nxt.flags = {ba_fl, ab_fl};
    s_nxt.flag_a = s_nxt.par_cfg[PC_EXTERNAL_FLAG_A] & (|s_nxt.perr);
    s_nxt.irq = |(s_nxt.perr & s_nxt.mask);

    // Read data stands for exactly one cycle
    s_nxt.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        FRP_REG_STATUS: begin
          s_nxt.rdata[7:0] = s_r.flags;
          s_nxt.rdata[FRP_ST_RD_PERR] = s_r.perr[0];
          s_nxt.rdata[FRP_ST_WR_PERR] = s_r.perr[1];
        end
        FRP_REG_MASK: begin
          s_nxt.rdata[FRP_ST_RD_PERR] = s_r.mask[0];
          s_nxt.rdata[FRP_ST_WR_PERR] = s_r.mask[1];
        end
        FRP_REG_CFG5: begin
          s_nxt.rdata[FRP_C5_REREAD_PR]  = s_r.prot[0];
          s_nxt.rdata[FRP_C5_REWRITE_PR] = s_r.prot[1];
        end
        FRP_REG_CFG7: begin
          s_nxt.rdata[FRP_C7_ERR_EXTERNAL_FLAG_A:FRP_C7_GEN_BA] = s_r.par_cfg;
        end
        FRP_REG_AB_AE: s_nxt.rdata[PW-1:0] = s_r.ab_ae;
        FRP_REG_AB_AF: s_nxt.rdata[PW-1:0] = s_r.ab_af;
        FRP_REG_BA_AE: s_nxt.rdata[PW-1:0] = s_r.ba_ae;
        FRP_REG_BA_AF: s_nxt.rdata[PW-1:0] = s_r.ba_af;
        default: s_nxt.rdata = '0;                           // Unmapped
      endcase
    end
  end

  // State register; both FIFOs come up empty
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r         <= '0;
      s_r.flags   <= FRP_FLAGS_RST;
      s_r.ab_ae   <= FRP_OFS_RST[PW-1:0];
      s_r.ab_af   <= FRP_OFS_RST[PW-1:0];
      s_r.ba_ae   <= FRP_OFS_RST[PW-1:0];
      s_r.ba_af   <= FRP_OFS_RST[PW-1:0];
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata            = s_r.rdata;
  assign ab_wr_addr           = s_r.ab_wr[AW-1:0];
  assign ab_rd_addr           = s_r.ab_rd[AW-1:0];
  assign ba_wr_addr           = s_r.ba_wr[AW-1:0];
  assign ba_rd_addr           = s_r.ba_rd[AW-1:0];
  assign fifo_flags           = s_r.flags;
  assign port_b_ninth_bit     = s_r.pb_ninth;
  assign port_a_low_ninth_bit = s_r.ba_ninth;
  assign external_flag_a      = s_r.flag_a;
  assign irq                  = s_r.irq;
endmodule // frp_fifo_ctrl
`default_nettype wire

/* File: bench/frp_fifo_ctrl_properties.sv */
/* Pointer and flag checker for frp_fifo_ctrl.
   Sees the top ports only; bound from the bench top file. */
`timescale 1ns/1ns
`default_nettype none
module frp_fifo_ctrl_props #(
  parameter int DEPTH = 512
) (
  input wire logic                     sys_clk,
  input wire logic                     rst,
  input wire logic                     ab_write,
  input wire logic                     ab_read,
  input wire logic                     ba_write,
  input wire logic                     reread_strobe,
  input wire logic                     save_read_mark,
  input wire logic                     rewrite_strobe,
  input wire logic                     save_write_mark,
  input wire logic [$clog2(DEPTH)-1:0] ab_wr_addr,
  input wire logic [$clog2(DEPTH)-1:0] ab_rd_addr,
  input wire logic [$clog2(DEPTH)-1:0] ba_wr_addr,
  input wire logic [7:0]               fifo_flags
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [$clog2(DEPTH)-1:0] rmark_r;
  logic [$clog2(DEPTH)-1:0] wmark_r;
  // Shadow marks, so restores can be judged without the bodies
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rmark_r <= '0;
      wmark_r <= '0;
    end else begin
      if (save_read_mark) rmark_r <= ab_rd_addr;
      if (save_write_mark) wmark_r <= ba_wr_addr;
    end
  end
  // Steps of the accepted operations
  sequence s_ab_push; ab_write && !fifo_flags[3]; endsequence
  sequence s_ab_pop; ab_read && !fifo_flags[0] && !reread_strobe; endsequence
  sequence s_reread; reread_strobe && !save_read_mark; endsequence
  sequence s_rewrite; rewrite_strobe && !save_write_mark; endsequence
  a_push_step: assert property (s_ab_push |=>
    ab_wr_addr == $past(ab_wr_addr) + 1'b1) else $error("push step wrong");
  a_full_refuse: assert property (ab_write && fifo_flags[3] |=>
    $stable(ab_wr_addr)) else $error("push taken while full");
  a_pop_step: assert property (s_ab_pop |=>
    ab_rd_addr == $past(ab_rd_addr) + 1'b1) else $error("pop step wrong");
  a_empty_refuse: assert property (ab_read && fifo_flags[0] &&
    !reread_strobe |=> $stable(ab_rd_addr)) else $error("pop while empty");
  a_reread_restore: assert property (s_reread |=>
    ab_rd_addr == $past(rmark_r)) else $error("reread mark not restored");
  a_rewrite_restore: assert property (s_rewrite |=>
    ba_wr_addr == $past(wmark_r)) else $error("rewrite mark not restored");
  a_ba_push_step: assert property (ba_write && !fifo_flags[7] &&
    !rewrite_strobe |=> ba_wr_addr == $past(ba_wr_addr) + 1'b1)
    else $error("push step wrong");
  a_empty_aempty: assert property (fifo_flags[0] |-> fifo_flags[1])
    else $error("empty without almost-empty");
endmodule // frp_fifo_ctrl_props
`default_nettype wire

/* File: bench/frp_ab_ram.sv */
/* Behavioural A-to-B memory facing the controller's address outputs.
   Assumes writes are gated by the caller when the FIFO is full. */
`timescale 1ns/1ns
`default_nettype none
module frp_ab_ram #(
  parameter int DEPTH = 512
) (
  input  wire logic                     sys_clk,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [8:0]               wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [7:0]               rbyte,
  output logic                          rninth
);
  logic [8:0] mem [DEPTH];
  // Word plus ninth bit stored together
  always_ff @(posedge sys_clk) begin
    if (we) mem[waddr] <= wdata;
  end
  assign {rninth, rbyte} = mem[raddr];
endmodule // frp_ab_ram
`default_nettype wire

/* File: bench/tb_frp_fifo_ctrl.sv */
/* Self-checking bench for frp_fifo_ctrl with a memory model.
   Assumes the package, design, model and checker compile first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  miscompares++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
  $time, (a), (b)); end end
module tb_frp_fifo_ctrl;
  import frp_pkg::*;
  localparam int D = 512;
  localparam logic [7:0] AW = 8'h80, AR = 8'h40, BW = 8'h20, BR = 8'h10;
  localparam logic [7:0] RR = 8'h08, SR = 8'h04, RW = 8'h02, SW = 8'h01;
  logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [7:0] st = 8'h00, fifo_flags, rbyte;
  logic [8:0] wd = 9'h000, ab_wr_addr, ab_rd_addr, ba_wr_addr, ba_rd_addr;
  logic rninth, port_b_ninth_bit, port_a_low_ninth_bit, external_flag_a, irq;
  int miscompares = 0, check_count = 0, cyc = 0;
  always #25 sys_clk = ~sys_clk;
  frp_fifo_ctrl #(.DEPTH(D)) frp_fifo_ctrl_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ab_write(st[7]), .ab_read(st[6]),
    .ba_write(st[5]), .ba_read(st[4]), .reread_strobe(st[3]),
    .save_read_mark(st[2]), .rewrite_strobe(st[1]),
    .save_write_mark(st[0]), .ab_rd_byte(rbyte), .ab_rd_ninth(rninth),
    .port_b_wr_byte(wd[7:0]), .port_b_wr_ninth(wd[8]),
    .ab_wr_addr(ab_wr_addr), .ab_rd_addr(ab_rd_addr),
    .ba_wr_addr(ba_wr_addr), .ba_rd_addr(ba_rd_addr),
    .fifo_flags(fifo_flags), .port_b_ninth_bit(port_b_ninth_bit),
    .port_a_low_ninth_bit(port_a_low_ninth_bit),
    .external_flag_a(external_flag_a), .irq(irq));
  frp_ab_ram #(.DEPTH(D)) frp_ab_ram_inst (
    .sys_clk(sys_clk), .we(st[7] && !fifo_flags[3]), .waddr(ab_wr_addr),
    .wdata(wd), .raddr(ab_rd_addr), .rbyte(rbyte), .rninth(rninth));
  // Expected {full, afull, aempty, empty} for offsets of 8
  function automatic logic [3:0] ef(input int c);
    return {c == D, c >= D - 8, c <= 8, c == 0};
  endfunction
  task automatic report_and_stop();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Data is looked at only in the one cycle it stands
  task automatic rreg(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  // Hold strobes s for n edges, one word per edge
  task automatic go(input logic [7:0] s, input int n, input logic [8:0] d);
    @(posedge sys_clk);
    st <= s;
    wd <= d;
    repeat (n) @(posedge sys_clk);
    st <= 8'h00;
    #1;
  endtask
  // Run takes about 2150 cycles; a hang is cut short well after
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rreg(FRP_REG_STATUS, 16'h0033);
    rreg(FRP_REG_BA_AF, 16'h0008);
    rreg(4'hF, 16'h0000);
    // All four parity modes on the port B write path
    for (int i = 0; i < 4; i++) begin
      wreg(FRP_REG_CFG7, {4'h0, i != 1, i[0], 1'b0, i[1], 8'h00});
      wreg(FRP_REG_MASK, i[0] ? 16'h0000 : 16'h0600);
      go(BW, 1, {i[0], 8'hA5});
      `CHK(port_a_low_ninth_bit, i[1] ? ~i[0] : i[0])
      rreg(FRP_REG_STATUS, {5'h00, !i[1], 2'h0, ef(i + 1), 4'h3});
      `CHK(external_flag_a, !i[1] && i != 1)
      `CHK(irq, !i[1] && !i[0])
      wreg(FRP_REG_STATUS, 16'h0600);
    end
    rreg(FRP_REG_STATUS, {8'h00, ef(4), 4'h3});
    `CHK(irq, 1'b0)
    // Block rewrite, then empty judged against the mark
    go(SW, 1, 9'h000);
    go(BW, 2, 9'h0A5);
    go(RW, 1, 9'h000);
    `CHK(ba_wr_addr, 9'h004)
    go(BW, 2, 9'h0A5);
    wreg(FRP_REG_CFG5, 16'h000C);
    go(BR, 4, 9'h000);
    `CHK(fifo_flags[7:4], 4'h3)
    go(BR, 1, 9'h000);
    `CHK(ba_rd_addr, 9'h004)
    // Fill A-to-B behind a saved block start, reread, then drain
    wreg(FRP_REG_CFG7, 16'h0200);
    go(SR, 1, 9'h000);
    for (int c = 1; c <= D; c++) begin
      go(AW, 1, 9'(c - 1));
      `CHK(fifo_flags[3:0], ef(c))
    end
    go(AW, 1, 9'h000);
    `CHK(ab_wr_addr, 9'h000)
    for (int k = 1; k <= 4; k++) begin
      go(AR, 1, 9'h000);
      `CHK(port_b_ninth_bit, ~^8'(k - 1))
      `CHK(fifo_flags[3:0], ef(D - k) | 4'h8)
    end
    go(RR, 1, 9'h000);
    `CHK(ab_rd_addr, 9'h000)
    wreg(FRP_REG_CFG5, 16'h0008);
    wreg(FRP_REG_CFG7, 16'h0000);
    go(AR, 2, 9'h000);
    go(RR, 1, 9'h000);
    `CHK(ab_rd_addr, 9'h000)
    for (int c = D - 1; c >= 0; c--) begin
      go(AR, 1, 9'h000);
      `CHK(fifo_flags[3:0], ef(c))
      `CHK(port_b_ninth_bit, 1'((D - 1 - c) >> 8))
    end
    go(AR, 1, 9'h000);
    `CHK(ab_rd_addr, 9'h000)
    rreg(FRP_REG_STATUS, 16'h0233);
    report_and_stop();
  end
endmodule // tb_frp_fifo_ctrl
bind frp_fifo_ctrl frp_fifo_ctrl_props #(.DEPTH(DEPTH)) props_inst (
  .sys_clk(sys_clk), .rst(rst), .ab_write(ab_write), .ab_read(ab_read),
  .ba_write(ba_write), .reread_strobe(reread_strobe),
  .save_read_mark(save_read_mark), .rewrite_strobe(rewrite_strobe),
  .save_write_mark(save_write_mark), .ab_wr_addr(ab_wr_addr),
  .ab_rd_addr(ab_rd_addr), .ba_wr_addr(ba_wr_addr),
  .fifo_flags(fifo_flags));
`default_nettype wire
